// [rtl/piu_pkg.sv]
/*
  Constants and types shared by the prioritized interrupt unit.
  Assumes a single 100 MHz system clock and an 8-bit core sequencer.
*/
package piu_pkg;
  localparam int PIU_NSRC = 15;
  localparam int PIU_IDXW = 4;
  localparam int PIU_VECW = 16;
  // Vectors step by eight bytes from the first service entry
  localparam logic [15:0] PIU_VEC_BASE = 16'h0003;
  localparam logic [15:0] PIU_VEC_STEP = 16'h0008;
  localparam int PIU_GIE_BIT = 7;
  localparam logic [7:0] PIU_EN_RST = 8'h00;
  localparam logic [PIU_NSRC-1:0] PIU_PEND_RST = 15'h0000;
  localparam logic [PIU_NSRC-1:0] PIU_PRIO_RST = 15'h0000;
  // Sources whose pending flag hardware clears on vectoring
  localparam logic [PIU_NSRC-1:0] PIU_AUTOCLR_DEF = 15'h000f;
  localparam real PIU_CLK_NS = 10.0;
  localparam int PIU_DETECT_CYC = 1;
  localparam int PIU_CALL_CYC = 4;
  localparam int PIU_RESP_CYC = PIU_DETECT_CYC + PIU_CALL_CYC;
  typedef enum logic [1:0] {
    PIU_IDLE = 2'b00,
    PIU_WAIT = 2'b01,
    PIU_CALL = 2'b11
  } piu_state_t;
endpackage

// [rtl/piu_arbiter.sv]
/*
  Fixed-order priority pick over a request vector; lowest index wins.
  Purely combinational; the caller registers what it needs.
*/
`timescale 1ns/10ps
module piu_arbiter
  import piu_pkg::*;
#(
  parameter int N = PIU_NSRC,
  parameter int W = PIU_IDXW
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule

// [rtl/piu_top.sv]
/*
  Prioritized interrupt unit: pending flags, enables, two-level priority,
  vector handoff to the core and return tracking.
  Assumes the core pulses instr_done at each instruction end, return_from_irq_instruction_done
  when a return-from-interrupt finishes, and call_ack when it takes the call.
*/
// Behaviour
// - Fifteen sources, each low or high priority
// - Valid trigger sets the pending flag
// - Flag sets regardless of enable
// - Enabled set flag raises core request
// - Core finishes instruction then calls vector
// - Routine ends with return; core resumes
// - Disabled source's flag is ignored
// - Per-source software enable bits
// - Individual enables need global enable high
// - Global enable low blocks all sources
// - Self-clearing flags clear on vectoring
// - Still-pending flag re-requests after one instruction
// - High preempts low; high never preempted
// - Higher level first, then fixed order
// - Decode every cycle; five-cycle best response
// - Equal/higher running: wait return plus instruction
`timescale 1ns/10ps
module piu_top
  import piu_pkg::*;
#(
  parameter int NSRC = PIU_NSRC,
  parameter logic [PIU_NSRC-1:0] AUTOCLR = PIU_AUTOCLR_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NSRC-1:0] src_trig,
  input wire logic [NSRC-1:0] sw_set,
  input wire logic [NSRC-1:0] sw_clr,
  input wire logic [7:0] primary_irq_enable_reg,
  input wire logic [7:0] extended_irq_enable_reg_one,
  input wire logic [NSRC-1:0] prio_high,
  input wire logic instr_done,
  input wire logic return_from_irq_instruction_done,
  input wire logic call_ack,
  output logic irq_req,
  output logic [PIU_VECW-1:0] irq_vector,
  output logic [PIU_IDXW-1:0] irq_src,
  output logic [NSRC-1:0] pending,
  output logic [1:0] active_lvl
);
  // Per-source views, one bit per source
  wire [NSRC-1:0] flags;
  wire [NSRC-1:0] live;
  wire [NSRC-1:0] live_hi;
  wire [NSRC-1:0] live_lo;
  wire [NSRC-1:0] clr_auto;

  // Call and routine bookkeeping
  piu_state_t st_q;
  piu_state_t st_d;
  logic [PIU_IDXW-1:0] win_q;
  logic [PIU_VECW-1:0] vec_q;
  logic win_hi_q;
  logic act_lo_q;
  logic act_hi_q;
  logic hold_q;

  // Arbiter results, one set per level
  logic any_hi;
  logic any_lo;
  logic [PIU_IDXW-1:0] idx_hi;
  logic [PIU_IDXW-1:0] idx_lo;

  wire global_irq_enable = primary_irq_enable_reg[PIU_GIE_BIT];
  wire [NSRC-1:0] src_en = {extended_irq_enable_reg_one[NSRC-8:0],
                            primary_irq_enable_reg[6:0]};
  // The vectoring event: the core takes the committed call
  wire take = (st_q == PIU_CALL) && call_ack;

  // One slice per source: pin synchroniser, pending flag and its gating
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    logic trig_s1_q;
    logic trig_s2_q;
    logic flag_q;
    wire set_ev = trig_s2_q || sw_set[g];
    wire clr_ev = sw_clr[g] || clr_auto[g];
    // Set beats clear so an event landing in the clearing cycle is kept
    wire flag_d = set_ev || (flag_q && !clr_ev);

    // The pin is asynchronous; only the second stage is read by logic
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        trig_s1_q <= 1'b0;
        trig_s2_q <= 1'b0;
      end else begin
        trig_s1_q <= src_trig[g];
        trig_s2_q <= trig_s1_q;
      end
    end

    // Software clears through sw_clr serve the flags hardware leaves set
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        flag_q <= PIU_PEND_RST[g];
      end else begin
        flag_q <= flag_d;
      end
    end

    assign flags[g] = flag_q;
    // A disabled source keeps its flag but never reaches the arbiters
    assign live[g] = flag_q && src_en[g] && global_irq_enable;
    assign live_hi[g] = live[g] && prio_high[g];
    assign live_lo[g] = live[g] && !prio_high[g];
    assign clr_auto[g] = take && AUTOCLR[g] && (win_q == PIU_IDXW'(g));
  end

  piu_arbiter #(.N(NSRC), .W(PIU_IDXW)) u_arb_hi (
    .req(live_hi),
    .any(any_hi),
    .idx(idx_hi)
  );
  piu_arbiter #(.N(NSRC), .W(PIU_IDXW)) u_arb_lo (
    .req(live_lo),
    .any(any_lo),
    .idx(idx_lo)
  );

  // High may enter unless a high routine runs; low only when nothing runs
  wire hi_ok = any_hi && !act_hi_q;
  wire lo_ok = any_lo && !act_hi_q && !act_lo_q;
  // A return in progress, and the one instruction after it, hold off calls
  wire gate_ok = !hold_q && !return_from_irq_instruction_done;
  wire win_ok = (hi_ok || lo_ok) && gate_ok;
  wire win_hi = hi_ok;
  wire [PIU_IDXW-1:0] win_idx = hi_ok ? idx_hi : idx_lo;
  wire [PIU_VECW-1:0] win_vec = PIU_VEC_BASE +
                                PIU_VECW'(PIU_VEC_STEP * PIU_VECW'(win_idx));
  // Winner is frozen once the call is committed so the vector stands
  wire capture = (st_q != PIU_CALL) && win_ok;

  // Opening a level wins over a return seen in the same cycle
  wire open_hi = take && win_hi_q;
  wire open_lo = take && !win_hi_q;
  // A return closes the most recent routine: the high one when it is open
  wire close_hi = return_from_irq_instruction_done && !take && act_hi_q;
  wire close_lo = return_from_irq_instruction_done && !take && !act_hi_q;

  // Request waits for the current instruction boundary before the call
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PIU_IDLE: begin
        if (win_ok) begin
          st_d = PIU_WAIT;
        end
      end
      PIU_WAIT: begin
        if (!win_ok) begin
          st_d = PIU_IDLE;
        end else if (instr_done) begin
          st_d = PIU_CALL;
        end
      end
      PIU_CALL: begin
        if (call_ack) begin
          st_d = PIU_IDLE;
        end
      end
      // The fourth code is never entered; recover to idle if it is
      default: begin
        st_d = PIU_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PIU_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      win_q <= '0;
    end else if (capture) begin
      win_q <= win_idx;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vec_q <= '0;
    end else if (capture) begin
      vec_q <= win_vec;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      win_hi_q <= 1'b0;
    end else if (capture) begin
      win_hi_q <= win_hi;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_hi_q <= 1'b0;
    end else if (open_hi) begin
      act_hi_q <= 1'b1;
    end else if (close_hi) begin
      act_hi_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_lo_q <= 1'b0;
    end else if (open_lo) begin
      act_lo_q <= 1'b1;
    end else if (close_lo) begin
      act_lo_q <= 1'b0;
    end
  end

  // After a return one more instruction runs before any new call
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 1'b0;
    end else if (return_from_irq_instruction_done) begin
      hold_q <= 1'b1;
    end else if (instr_done) begin
      hold_q <= 1'b0;
    end
  end

  assign irq_req = (st_q == PIU_CALL);
  assign irq_vector = vec_q;
  assign irq_src = win_q;
  assign pending = flags;
  assign active_lvl = {act_hi_q, act_lo_q};
endmodule

// [test/piu_core_model.sv]
/* Core stand-in: instruction ends, call taking, returns.
   Assumes ret_cmd comes from the bench. */
`timescale 1ns/10ps
module piu_core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire logic ret_cmd,
  output logic instr_done,
  output logic return_from_irq_instruction_done,
  output logic call_ack
);
  // Two-cycle instructions, so a boundary is not always at hand
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      instr_done <= 1'h0;
      call_ack <= 1'h0;
    end else begin
      instr_done <= !instr_done;
      call_ack <= irq_req && !call_ack;
    end
  end
  assign return_from_irq_instruction_done = ret_cmd;
endmodule

// [test/piu_top_sva.sv]
/* Port checker for piu_top.
   Bound from the bench top file. */
`timescale 1ns/10ps
module piu_top_sva
  import piu_pkg::*;
#(
  parameter int NSRC = PIU_NSRC,
  parameter logic [PIU_NSRC-1:0] AUTOCLR = PIU_AUTOCLR_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NSRC-1:0] src_trig,
  input wire logic [NSRC-1:0] sw_set,
  input wire logic [7:0] primary_irq_enable_reg,
  input wire logic instr_done,
  input wire logic return_from_irq_instruction_done,
  input wire logic call_ack,
  input wire logic irq_req,
  input wire logic [PIU_VECW-1:0] irq_vector,
  input wire logic [PIU_IDXW-1:0] irq_src,
  input wire logic [NSRC-1:0] pending,
  input wire logic [1:0] active_lvl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    irq_req && call_ack;
  endsequence
  chk_vec_value: assert property (
    irq_req |-> irq_vector == PIU_VEC_BASE + PIU_VEC_STEP * irq_src) else $error("bad vector");
  chk_req_drop: assert property (s_take |=> !irq_req) else $error("req held");
  chk_auto_clear: assert property (
    s_take ##0 (AUTOCLR[irq_src] && !sw_set[irq_src] && $past(src_trig, 2) == '0)
    |=> !pending[$past(irq_src)])
    else $error("flag kept");
  chk_set_flag: assert property (sw_set != 15'h0 |=>
    (pending & $past(sw_set)) == $past(sw_set)) else $error("flag not set");
  chk_at_boundary: assert property ($rose(irq_req) |-> $past(instr_done)) else $error("mid");
  chk_global_gate: assert property (
    $rose(irq_req) |-> $past(primary_irq_enable_reg[PIU_GIE_BIT])) else $error("gated");
  chk_high_solo: assert property (irq_req |-> !active_lvl[1]) else $error("preempted");
  chk_return_hold: assert property (return_from_irq_instruction_done |=> !$rose(irq_req)) else $error("no hold");
endmodule

// [test/piu_top_test.sv]
/* Bench for piu_top with a core stand-in.
   Assumes checker and core model are compiled first. */
`timescale 1ns/10ps
module piu_top_test;
  logic mclk = 1'h0, arst_n = 1'h0, ret_cmd = 1'h0, instr_done, return_from_irq_instruction_done, call_ack, irq_req;
  logic [14:0] src_trig = 15'h0, sw_set = 15'h0, sw_clr = 15'h0, prio_high = 15'h0200, pending;
  logic [7:0] ie = 8'h10, eie = 8'h04;
  logic [15:0] irq_vector;
  logic [3:0] irq_src;
  logic [1:0] active_lvl;
  int n_mismatch = 0, check_count = 0;
  always #5 mclk = !mclk;
  piu_top dut (.mclk, .arst_n, .src_trig, .sw_set, .sw_clr, .prio_high,
    .primary_irq_enable_reg(ie), .extended_irq_enable_reg_one(eie), .instr_done,
    .return_from_irq_instruction_done, .call_ack, .irq_req, .irq_vector, .irq_src, .pending, .active_lvl);
  piu_core_model core (.mclk, .arst_n, .irq_req, .ret_cmd, .instr_done, .return_from_irq_instruction_done,
    .call_ack);
  task automatic chk(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic go(input logic [14:0] s, c, input logic r);
    sw_set = s;
    sw_clr = c;
    ret_cmd = r;
    @(negedge mclk);
    sw_set = 15'h0;
    sw_clr = 15'h0;
    ret_cmd = 1'h0;
    // An idle edge keeps back-to-back calls from rewriting a strobe at once
    @(negedge mclk);
  endtask
  // Waits for a call, then checks who won and the level taken
  task automatic take(input logic [3:0] src, input logic [1:0] lvl);
    int i;
    for (i = 0; i < 20 && irq_req !== 1'h1; i++)
      @(negedge mclk);
    if (i == 20) begin
      chk(16'h0, 16'h1);
      test_done();
    end else begin
      chk(irq_src, src);
      chk(irq_vector, 16'h0003 + 16'h0008 * src);
      repeat (2) @(negedge mclk);
      chk(active_lvl, lvl);
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'h1;
    go(15'h0010, 15'h0, 1'h0);
    repeat (6) @(negedge mclk);
    chk(pending, 15'h0010);
    chk(irq_req, 1'h0);
    ie = 8'h94;
    take(4'h4, 2'h1);
    chk(pending, 15'h0010);
    go(15'h0, 15'h0010, 1'h0);
    go(15'h0, 15'h0, 1'h1);
    go(15'h0204, 15'h0, 1'h0);
    take(4'h9, 2'h2);
    repeat (4) @(negedge mclk);
    chk(irq_req, 1'h0);
    go(15'h0, 15'h0200, 1'h0);
    go(15'h0, 15'h0, 1'h1);
    take(4'h2, 2'h1);
    chk(pending, 15'h0000);
    go(15'h0204, 15'h0, 1'h0);
    take(4'h9, 2'h3);
    go(15'h0, 15'h0200, 1'h0);
    go(15'h0, 15'h0, 1'h1);
    repeat (4) @(negedge mclk);
    chk(active_lvl, 2'h1);
    go(15'h0, 15'h0, 1'h1);
    take(4'h2, 2'h1);
    go(15'h0, 15'h0, 1'h1);
    ie = 8'h95;
    src_trig = 15'h0001;
    @(negedge mclk);
    src_trig = 15'h0000;
    take(4'h0, 2'h1);
    chk(pending, 15'h0000);
    test_done();
  end
endmodule
bind piu_top piu_top_sva #(.NSRC(NSRC), .AUTOCLR(AUTOCLR)) chk_i (.mclk, .arst_n, .src_trig, .sw_set,
  .primary_irq_enable_reg, .instr_done, .return_from_irq_instruction_done, .call_ack, .irq_req, .irq_vector,
  .irq_src, .pending, .active_lvl);
